// File: core/seec_pkg.sv
/*
  seec_pkg: constants and carrier types for the serial eeprom controller.
  assumes a 40 MHz core clock and a three-wire 128 x 8 eeprom.
*/
`default_nettype none
package seec_pkg;
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned TIMEOUT_MS     = 30;
  localparam int unsigned TIMEOUT_CYC    = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned SCLK_HALF_CYC  = 20;  // 1 MHz serial clock
  localparam logic [7:0]  SIGNATURE      = 8'ha5;
  localparam logic [6:0]  SIG_LOCATION   = 7'h00;
  localparam int unsigned ADDR_BYTES     = 6;
  localparam logic [5:0]  SHORT_CYCLES   = 6'h0a;
  localparam logic [5:0]  LONG_CYCLES    = 6'h12;
  localparam logic [5:0]  WAIT_CYCLES    = 6'h3f;
  localparam logic [47:0] STATION_RESET  = 48'hffffffffffff;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  OP_ERASE       = 2'h3;
  localparam logic [1:0]  OP_EXT         = 2'h0;
  localparam logic [1:0]  EXT_DISABLE    = 2'h0;
  localparam logic [1:0]  EXT_WRITE_ALL  = 2'h1;
  localparam logic [1:0]  EXT_ERASE_ALL  = 2'h2;
  localparam logic [1:0]  EXT_ENABLE     = 2'h3;

  typedef enum logic [2:0] {
    CMD_READ, CMD_ERASE_WRITE_DISABLE, CMD_ERASE_WRITE_ENABLE,
    CMD_WRITE, CMD_WRITE_ALL_LOCATIONS, CMD_ERASE,
    CMD_ERASE_ALL_LOCATIONS, CMD_RELOAD
  } seec_cmd_e;

  typedef struct packed {
    logic      command_busy_flag;
    seec_cmd_e command_code_field;
    logic [6:0] target_location_field;
  } seec_cmd_s;

  typedef struct packed {
    logic cs;
    logic sclk;
    logic dout;
    logic dout_oe;
  } seec_pins_s;
endpackage : seec_pkg
`default_nettype wire

// File: core/seec_ctrl.sv
/*
  seec_ctrl: serial eeprom controller with auto-load of the station address.
  assumes host-side register bits arrive as plain ports on clk; the data
  pin returns asynchronously and is synchronised here.
*/
`default_nettype none
module seec_ctrl (
  input  wire logic               clk,            // 40 MHz core clock
  input  wire logic               reset_n,        // async reset, active low
  input  wire logic               soft_reset,     // pulse: rerun auto-load
  input  wire seec_pkg::seec_cmd_s cmd_in,        // command write value
  input  wire logic               cmd_we,         // pulse: write command reg
  input  wire logic [7:0]         data_in,        // data register write value
  input  wire logic               data_we,        // pulse: write data reg
  input  wire logic               if_disable,     // pin config: eeprom off
  input  wire logic               alt_sel,        // 1: monitor, 0: gp outputs
  input  wire logic [1:0]         gp_out,         // general-purpose pin values
  input  wire logic [1:0]         mon_in,         // internal monitor signals
  input  wire logic               serial_data_pin_i, // data pin in
  output logic                    serial_data_pin_o, // data pin out
  output logic                    serial_data_pin_oe, // data pin enable
  output logic                    eeprom_clock_pin,   // serial clock pin
  output logic                    eeprom_cs,          // chip select
  output logic [10:0]             eeprom_command_reg, // busy,code,location
  output logic                    response_timeout_flag, // sticky timeout
  output logic                    address_loaded,     // station addr valid
  output logic [7:0]              eeprom_data_reg,    // data register
  output logic [15:0]             station_address_high, // bytes 5..4
  output logic [31:0]             station_address_low   // bytes 3..0
);
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_SHIFT, S_GAP, S_WAIT, S_NEXT
  } seec_state_e;

  ////////////////////////////////////////////////////////////////////////////
  seec_state_e state_q;
  seec_pkg::seec_cmd_s cmd_q;
  logic        auto_q;        // auto-load in progress
  logic [2:0]  byte_idx_q;    // 0 = signature, 1..6 address bytes
  logic [5:0]  bit_cnt_q;
  logic [5:0]  bit_total_q;
  logic [17:0] shreg_q;
  logic [7:0]  rx_q;
  logic [4:0]  div_q;
  logic        sclk_q;
  logic        cs_q;
  logic [20:0] to_cnt_q;
  logic        to_q;
  logic        loaded_q;
  logic [7:0]  data_q;
  logic [47:0] station_q;
  logic        din_m_q, din_q;
  logic        start_up_q;    // request auto-load after reset release
  logic        pin_d_q, pin_oe_q, pin_c_q;
  logic        busy_q;        // registered busy seen by the host

  // two-flop sync on the data pin, only din_q is read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      din_m_q <= 1'b0;
      din_q   <= 1'b0;
    end else begin
      din_m_q <= serial_data_pin_i;
      din_q   <= din_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire       busy      = (state_q != S_IDLE);
  wire       half_tick = (div_q == 5'(seec_pkg::SCLK_HALF_CYC - 1));
  wire       rise      = half_tick && !sclk_q;
  wire       fall      = half_tick && sclk_q;
  wire       host_go   = cmd_we && cmd_in.command_busy_flag && !busy;
  wire       auto_go   = start_up_q || soft_reset;
  wire       reload_go = host_go &&
                         cmd_in.command_code_field == seec_pkg::CMD_RELOAD;
  wire [6:0] auto_loc  = 7'(byte_idx_q);
  wire       timed_out = (to_cnt_q == 21'(seec_pkg::TIMEOUT_CYC - 1));
  wire       sig_ok    = (rx_q == seec_pkg::SIGNATURE);
  wire       is_read   = auto_q ||
                         cmd_q.command_code_field == seec_pkg::CMD_READ;
  wire       needs_ack =
    !auto_q && (cmd_q.command_code_field == seec_pkg::CMD_WRITE ||
                cmd_q.command_code_field == seec_pkg::CMD_WRITE_ALL_LOCATIONS ||
                cmd_q.command_code_field == seec_pkg::CMD_ERASE ||
                cmd_q.command_code_field == seec_pkg::CMD_ERASE_ALL_LOCATIONS);

  // start bit, 2-bit opcode, 7-bit location, then 8 data bits if any
  function automatic logic [17:0] frame(input seec_pkg::seec_cmd_e c,
                                        input logic [6:0] loc,
                                        input logic [7:0] d);
    logic [1:0] op;
    logic [6:0] a;
    op = seec_pkg::OP_EXT;
    a  = loc;
    case (c)
      seec_pkg::CMD_READ:  op = seec_pkg::OP_READ;
      seec_pkg::CMD_WRITE: op = seec_pkg::OP_WRITE;
      seec_pkg::CMD_ERASE: op = seec_pkg::OP_ERASE;
      seec_pkg::CMD_ERASE_WRITE_DISABLE: a = {seec_pkg::EXT_DISABLE, 5'h00};
      seec_pkg::CMD_ERASE_WRITE_ENABLE:  a = {seec_pkg::EXT_ENABLE, 5'h00};
      seec_pkg::CMD_WRITE_ALL_LOCATIONS: a = {seec_pkg::EXT_WRITE_ALL, 5'h00};
      seec_pkg::CMD_ERASE_ALL_LOCATIONS: a = {seec_pkg::EXT_ERASE_ALL, 5'h00};
      default: op = seec_pkg::OP_READ;
    endcase
    return {1'b1, op, a, d};
  endfunction : frame

  // 10 clocks for opcode-only commands, 18 with a data byte
  function automatic logic [5:0] cycles(input seec_pkg::seec_cmd_e c);
    case (c)
      seec_pkg::CMD_READ, seec_pkg::CMD_WRITE,
      seec_pkg::CMD_WRITE_ALL_LOCATIONS, seec_pkg::CMD_RELOAD:
        return seec_pkg::LONG_CYCLES;
      default: return seec_pkg::SHORT_CYCLES;
    endcase
  endfunction : cycles

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) start_up_q <= 1'b1;
    else          start_up_q <= 1'b0;
  end

  // serial clock divider, free-running only while a frame is active
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 5'h00;
    end else if (state_q == S_SHIFT && !half_tick) begin
      div_q <= div_q + 5'h01;
    end else begin
      div_q <= 5'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= S_IDLE;
      cmd_q       <= '0;
      auto_q      <= 1'b0;
      byte_idx_q  <= 3'h0;
      bit_cnt_q   <= 6'h00;
      bit_total_q <= 6'h00;
      shreg_q     <= 18'h00000;
      rx_q        <= 8'h00;
      sclk_q      <= 1'b0;
      cs_q        <= 1'b0;
      to_cnt_q    <= 21'h000000;
      to_q        <= 1'b0;
      loaded_q    <= 1'b0;
      data_q      <= 8'h00;
      station_q   <= seec_pkg::STATION_RESET;
    end else begin
      if (data_we && !busy) data_q <= data_in;
      if (busy) to_cnt_q <= to_cnt_q + 21'h000001;
      case (state_q)
        S_IDLE: begin
          to_cnt_q <= 21'h000000;
          if (auto_go || reload_go) begin
            auto_q     <= 1'b1;
            byte_idx_q <= 3'h0;
            loaded_q   <= 1'b0;
            cmd_q      <= '0;
            state_q    <= S_START;
          end else if (host_go) begin
            auto_q  <= 1'b0;
            cmd_q   <= cmd_in;
            to_q    <= 1'b0;
            state_q <= S_START;
          end
        end
        S_START: begin
          cs_q      <= 1'b1;
          bit_cnt_q <= 6'h00;
          if (auto_q) begin
            shreg_q     <= frame(seec_pkg::CMD_READ, auto_loc, 8'h00);
            bit_total_q <= seec_pkg::LONG_CYCLES;
          end else begin
            shreg_q     <= frame(cmd_q.command_code_field,
                                 cmd_q.target_location_field, data_q);
            bit_total_q <= cycles(cmd_q.command_code_field);
          end
          state_q <= S_SHIFT;
        end
        S_SHIFT: begin
          if (rise) begin
            sclk_q <= 1'b1;
            rx_q   <= {rx_q[6:0], din_q};
          end else if (fall) begin
            sclk_q    <= 1'b0;
            shreg_q   <= {shreg_q[16:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 6'h01;
            if (bit_cnt_q == bit_total_q - 6'h01) state_q <= S_GAP;
          end
        end
        S_GAP: begin
          cs_q      <= 1'b0;
          bit_cnt_q <= 6'h00;
          state_q   <= needs_ack ? S_WAIT : S_NEXT;
        end
        S_WAIT: begin
          // ready shows as data high after chip select is raised again
          cs_q <= 1'b1;
          if (bit_cnt_q != seec_pkg::WAIT_CYCLES) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
          end else if (din_q) begin
            cs_q    <= 1'b0;
            state_q <= S_IDLE;
          end
          if (timed_out) begin
            cs_q    <= 1'b0;
            to_q    <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_NEXT: begin
          state_q <= S_IDLE;
          if (!auto_q) begin
            if (is_read) data_q <= rx_q;
          end else if (byte_idx_q == 3'h0) begin
            if (sig_ok) begin
              byte_idx_q <= 3'h1;
              state_q    <= S_START;
            end
            // mismatch: station address untouched, loaded stays low
          end else begin
            station_q[8*(byte_idx_q-3'h1) +: 8] <= rx_q;
            if (byte_idx_q == 3'(seec_pkg::ADDR_BYTES)) begin
              loaded_q <= 1'b1;
            end else begin
              byte_idx_q <= byte_idx_q + 3'h1;
              state_q    <= S_START;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin mux: when disabled, pins become gp outputs or monitor taps
  wire [1:0] alt_val = alt_sel ? mon_in : gp_out;
  wire       mux_d   = if_disable ? alt_val[0] : shreg_q[17];
  wire       mux_oe  = if_disable ? 1'b1 : (state_q == S_SHIFT && !is_read) ||
                       (state_q == S_SHIFT && bit_cnt_q < seec_pkg::SHORT_CYCLES);
  wire       mux_c   = if_disable ? alt_val[1] : sclk_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_d_q  <= 1'b0;
      pin_oe_q <= 1'b0;
      pin_c_q  <= 1'b0;
    end else begin
      pin_d_q  <= mux_d;
      pin_oe_q <= mux_oe;
      pin_c_q  <= mux_c;
    end
  end

  assign serial_data_pin_o     = pin_d_q;
  assign serial_data_pin_oe    = pin_oe_q;
  assign eeprom_clock_pin      = pin_c_q;
  assign eeprom_cs             = cs_q;
  assign eeprom_command_reg    = {busy_q, cmd_q.command_code_field,
                                  cmd_q.target_location_field};
  assign response_timeout_flag = to_q;
  assign address_loaded        = loaded_q;
  assign eeprom_data_reg       = data_q;
  assign station_address_high  = station_q[47:32];
  assign station_address_low   = station_q[31:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) busy_q <= 1'b1;
    else          busy_q <= busy || auto_go || host_go;
  end

  ////////////////////////////////////////////////////////////////////////////
  busy_on_go_a: assert property (@(posedge clk) disable iff (!reset_n)
    host_go |=> busy) else $error("busy not set after command");
  load_sets_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(loaded_q) |-> $past(state_q) == S_NEXT &&
      $past(byte_idx_q) == 3'(seec_pkg::ADDR_BYTES))
    else $error("address loaded without signature");
  mismatch_keeps_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == S_NEXT && auto_q && byte_idx_q == 3'h0 && !sig_ok)
    |=> $stable(station_q) && state_q == S_IDLE)
    else $error("station address changed on mismatch");
  read_data_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == S_NEXT && !auto_q && is_read) |=> data_q == $past(rx_q))
    else $error("read byte not in data register");
  timeout_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == S_WAIT && timed_out) |=> to_q && state_q == S_IDLE)
    else $error("timeout not flagged");
  auto_start_a: assert property (@(posedge clk) disable iff (!reset_n)
    start_up_q |=> auto_q && state_q == S_START)
    else $error("auto-load not started after reset");
  short_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == S_START && !auto_q &&
     cmd_q.command_code_field == seec_pkg::CMD_ERASE)
    |=> bit_total_q == 6'h0a) else $error("erase clock count wrong");
  disable_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    if_disable |=> serial_data_pin_oe)
    else $error("disabled pin not driven");
endmodule : seec_ctrl
`default_nettype wire

// File: dv/seec_eeprom_model.sv
/*
  seec_eeprom_model: behavioural 128 x 8 three-wire serial eeprom.
  assumes frames are framed by cs and bits are taken on rising sclk.
*/
`default_nettype none
module seec_eeprom_model (
  input  wire logic cs,   // chip select
  input  wire logic sclk, // serial clock
  input  wire logic din,  // data from controller
  output logic      dout  // data to controller
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [128];
  logic [17:0] sh;
  logic [1:0]  op;
  logic [6:0]  loc;
  int          edges;
  int          frame_edges; // clocks seen in the last real frame
  bit          ew_en;
  initial dout = 1'b0;
  always @(posedge cs) begin
    edges = 0;
  end
  always @(posedge sclk) begin
    if (cs) begin
      edges++;
      sh = {sh[16:0], din};
      if (edges == 10) {op, loc} = sh[8:0];
    end
  end
  ////////////////////////////////////////////////////////////
  // read data changes after the falling edge, msb first
  always @(negedge sclk) begin
    if (cs && op == seec_pkg::OP_READ && edges >= 10 && edges < 18)
      dout = mem[loc][17 - edges];
  end
  // released line shows the inverse of its last level
  // a ready poll carries no clocks and must not count as a frame
  always @(negedge cs) begin
    if (edges > 0) begin
      frame_edges = edges;
      edges = 0;
      if (op == seec_pkg::OP_READ || (op == seec_pkg::OP_EXT &&
          loc[6:5] inside {seec_pkg::EXT_DISABLE, seec_pkg::EXT_ENABLE})) begin
        if (op == seec_pkg::OP_EXT) ew_en = loc[6:5] == seec_pkg::EXT_ENABLE;
        dout = ~dout;
      end else begin
        if (ew_en && op == seec_pkg::OP_WRITE) mem[loc] = sh[7:0];
        if (ew_en && op == seec_pkg::OP_ERASE) mem[loc] = 8'hff;
        if (ew_en && op == seec_pkg::OP_EXT)
          for (int i = 0; i < 128; i++)
            mem[i] = loc[6:5] == seec_pkg::EXT_WRITE_ALL ? sh[7:0] : 8'hff;
        // busy low, then ready high until the next frame
        dout = 1'b0;
        #4000 dout = 1'b1;
      end
    end
  end
endmodule : seec_eeprom_model
`default_nettype wire

// File: dv/tb_top.sv
/*
  tb_top: directed bench for seec_ctrl with an eeprom model on its pins.
  assumes the 40 MHz clock and a model that never times out.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, soft_reset = 1'b0;
  logic cmd_we = 1'b0, data_we = 1'b0, if_disable = 1'b0, alt_sel = 1'b0;
  logic [1:0] gp_out = 2'h0, mon_in = 2'h0;
  logic [7:0] data_in = 8'h00, data_reg;
  seec_pkg::seec_cmd_s cmd_in = '0;
  logic pin_o, pin_oe, sclk, cs, to_flag, loaded, model_dout;
  logic [10:0] cmd_reg;
  logic [15:0] sa_hi;
  logic [31:0] sa_lo;
  wire  pin_i = pin_oe ? pin_o : model_dout;
  int   err_total = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  seec_ctrl dut_u (.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .cmd_in(cmd_in), .cmd_we(cmd_we), .data_in(data_in), .data_we(data_we),
    .if_disable(if_disable), .alt_sel(alt_sel), .gp_out(gp_out),
    .mon_in(mon_in), .serial_data_pin_i(pin_i), .serial_data_pin_o(pin_o),
    .serial_data_pin_oe(pin_oe), .eeprom_clock_pin(sclk), .eeprom_cs(cs),
    .eeprom_command_reg(cmd_reg), .response_timeout_flag(to_flag),
    .address_loaded(loaded), .eeprom_data_reg(data_reg),
    .station_address_high(sa_hi), .station_address_low(sa_lo));
  seec_eeprom_model model_u (.cs(cs), .sclk(sclk), .din(pin_o),
    .dout(model_dout));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [47:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic wait_idle();
    int n;
    n = 0;
    while (cmd_reg[10] !== 1'b0) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 20000) begin
        err_total++;
        stop_test();
      end
    end
  endtask : wait_idle
  task automatic run_cmd(input seec_pkg::seec_cmd_e code,
                         input logic [6:0] loc, input int edges);
    @(posedge clk);
    cmd_in <= '{1'b1, code, loc};
    cmd_we <= 1'b1;
    @(posedge clk);
    cmd_we <= 1'b0;
    @(posedge clk);
    #1;
    check("busy", cmd_reg[10], 1'b1);
    wait_idle();
    check("clocks", model_u.frame_edges, edges);
  endtask : run_cmd
  task automatic rd(input logic [6:0] loc, input logic [7:0] exp);
    run_cmd(seec_pkg::CMD_READ, loc, 18);
    check("read data", data_reg, exp);
  endtask : rd
  task automatic wr(input seec_pkg::seec_cmd_e code,
                    input logic [6:0] loc, input logic [7:0] d);
    @(posedge clk);
    data_in <= d;
    data_we <= 1'b1;
    @(posedge clk);
    data_we <= 1'b0;
    run_cmd(code, loc, 18);
  endtask : wr
  task automatic check_sa(input logic ld, input logic [47:0] exp);
    check("loaded", loaded, ld);
    check("station", {sa_hi, sa_lo}, exp);
  endtask : check_sa
  task automatic restart(input bit hard);
    @(posedge clk);
    reset_n <= !hard;
    soft_reset <= !hard ? 1'b1 : 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    soft_reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("load busy", cmd_reg[10], 1'b1);
    wait_idle();
  endtask : restart
  ////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 128; i++) model_u.mem[i] = i < 7 ? 8'(i * 17) : 8'h00;
    model_u.mem[0] = 8'ha5;
    repeat (4) @(posedge clk);
    restart(1'b0);
    check_sa(1'b1, 48'h665544332211);
    rd(7'h05, 8'h55);
    wr(seec_pkg::CMD_WRITE, 7'h09, 8'h3c);
    rd(7'h09, 8'h00);
    run_cmd(seec_pkg::CMD_ERASE_WRITE_ENABLE, 7'h00, 10);
    wr(seec_pkg::CMD_WRITE, 7'h09, 8'h3c);
    rd(7'h09, 8'h3c);
    run_cmd(seec_pkg::CMD_ERASE, 7'h09, 10);
    rd(7'h09, 8'hff);
    run_cmd(seec_pkg::CMD_ERASE_WRITE_DISABLE, 7'h00, 10);
    wr(seec_pkg::CMD_WRITE, 7'h09, 8'h7e);
    rd(7'h09, 8'hff);
    run_cmd(seec_pkg::CMD_ERASE_WRITE_ENABLE, 7'h00, 10);
    wr(seec_pkg::CMD_WRITE_ALL_LOCATIONS, 7'h00, 8'h5a);
    rd(7'h7f, 8'h5a);
    run_cmd(seec_pkg::CMD_ERASE_ALL_LOCATIONS, 7'h00, 10);
    rd(7'h00, 8'hff);
    restart(1'b1);
    check_sa(1'b0, 48'hffffffffffff);
    run_cmd(seec_pkg::CMD_RELOAD, 7'h00, 18);
    check_sa(1'b0, 48'hffffffffffff);
    wr(seec_pkg::CMD_WRITE_ALL_LOCATIONS, 7'h00, 8'ha5);
    restart(1'b0);
    check_sa(1'b1, {6{8'ha5}});
    wr(seec_pkg::CMD_WRITE, 7'h01, 8'h12);
    run_cmd(seec_pkg::CMD_RELOAD, 7'h00, 18);
    check_sa(1'b1, 48'ha5a5a5a5a512);
    check("timeout", to_flag, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      if_disable <= 1'b1;
      alt_sel <= k[0];
      gp_out <= 2'h2;
      mon_in <= 2'h1;
      repeat (3) @(posedge clk);
      #1;
      check("pins", {pin_oe, sclk, pin_o}, k ? 3'h5 : 3'h6);
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
